// [hw/burst4_pkg.sv]
// Shared constants and types for the burst-of-four memory link
// Function
// - Read select low at K rise latches address
// - Loop on: first word 2.5 cycles later
// - Loop disabled: read latency one cycle
// - Read on consecutive K rises is ignored
// - Read deselect: finish burst, tristate after K#
// - Write select low; four words follow, commit
// - Write on consecutive K rises is ignored
// - Write deselect: finish pending, ignore inputs
// - Byte selects per word; deasserted keeps byte
// - Select b covers data bits [9b+8:9b]
// - Read after write returns newest data
// - Both selects: arbitrate on previous operation
// - Selects sampled at K rise only
// - Data in and out on K, K# rises
// - Impedance recalibration every 1024 cycles
// - Two free-running echo clocks, K and K#
// - Valid flag half cycle before data
// - Loop locks after 20 us stable clock
// - Clock stop of 30 ns restarts host lock wait; device loop keeps lock
// - Burst covers A, A+1, A+2, A+3 ascending
// - Power-up: deselected, read outputs off
package burst4_pkg;
    localparam int DATA_W         = 18;
    localparam int BYTE_W         = 9;
    localparam int ADDR_W         = 8;
    localparam int BURST          = 4;
    localparam int RD_PIPE        = 5;
    localparam int LAT_LOOP_BEATS = 5;
    localparam int LAT_LEG_BEATS  = 2;
    localparam int WR_LAST_SLOT   = 5;
    localparam int CAL_K_CYCLES   = 1024;
    localparam int LOCK_TIME_NS   = 20000;
    localparam int K_PERIOD_NS    = 64;
    localparam int LOCK_K_CYCLES  = (LOCK_TIME_NS + K_PERIOD_NS - 1) / K_PERIOD_NS;
    localparam int CLK_PERIOD_NS  = 10;
    localparam int LOCK_WAIT_CYC  = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STOP_TIME_NS   = 30;
    localparam int STOP_CYC       = (STOP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Last operation started on a K rise
    typedef enum logic [1:0] {
        OP_IDLE = 2'b00,
        OP_RD   = 2'b01,
        OP_WR   = 2'b11
    } op_e;

    // Host link states
    typedef enum logic [1:0] {
        HS_WAIT = 2'b00,
        HS_RUN  = 2'b01,
        HS_STOP = 2'b11
    } host_state_e;
endpackage

// [hw/burst4_if.sv]
// Link between the memory controller and the burst-four memory
`timescale 1ns/1ns
`default_nettype none
interface burst4_if #(
    parameter int AW = burst4_pkg::ADDR_W
);
    localparam int W  = burst4_pkg::DATA_W;
    localparam int NB = burst4_pkg::DATA_W / burst4_pkg::BYTE_W;

    logic          beat_clk;
    logic          k_true;
    logic          read_port_select_n;
    logic          write_port_select_n;
    logic [AW-1:0] addr;
    logic [W-1:0]  wdata;
    logic [NB-1:0] byte_write_select_n;
    logic [W-1:0]  rdata;
    logic          rdata_oe;
    logic          read_valid_flag;
    logic          echo_clock;
    logic          echo_clock_n;

    modport device (
        input  beat_clk,
        input  k_true,
        input  read_port_select_n,
        input  write_port_select_n,
        input  addr,
        input  wdata,
        input  byte_write_select_n,
        output rdata,
        output rdata_oe,
        output read_valid_flag,
        output echo_clock,
        output echo_clock_n
    );

    modport host (
        output beat_clk,
        output k_true,
        output read_port_select_n,
        output write_port_select_n,
        output addr,
        output wdata,
        output byte_write_select_n,
        input  rdata,
        input  rdata_oe,
        input  read_valid_flag,
        input  echo_clock,
        input  echo_clock_n
    );
endinterface
`default_nettype wire

// [hw/burst4_mem_device.sv]
// Burst-of-four memory end, clocked by the link beat clock
`timescale 1ns/1ns
`default_nettype none
module burst4_mem_device #(
    parameter int AW = burst4_pkg::ADDR_W
) (
    burst4_if.device          lnk,
    input  wire logic         rst_b,
    input  wire logic         loop_disable_n,
    output logic              loop_locked,
    output logic              cal_tick
);
    localparam int W     = burst4_pkg::DATA_W;
    localparam int BW    = burst4_pkg::BYTE_W;
    localparam int NB    = W / BW;
    localparam int DEPTH = 2 ** (AW + 2);
    localparam int LW    = $clog2(burst4_pkg::LOCK_K_CYCLES + 1);
    localparam int CW    = $clog2(burst4_pkg::CAL_K_CYCLES);

    logic [W-1:0]      mem [0:DEPTH-1];
    logic              ld_s1_q;
    logic              ld_s2_q;
    burst4_pkg::op_e   last_q;
    logic              rd_go;
    logic              wr_go;
    logic [burst4_pkg::RD_PIPE-1:0] rg_q;
    logic [AW-1:0]     ra_q [0:burst4_pkg::RD_PIPE-1];
    logic [burst4_pkg::WR_LAST_SLOT-1:0] wg_q;
    logic [AW-1:0]     pend_a_q;
    logic [AW-1:0]     wb_a_q;
    logic [W-1:0]      wb_d_q [0:burst4_pkg::BURST-1];
    logic [NB-1:0]     wb_m_q [0:burst4_pkg::BURST-1];
    logic [burst4_pkg::BURST-1:0] wb_vld_q;
    logic [2:0]        lat;
    logic              rd_start;
    logic              rd_pre;
    logic [AW-1:0]     cur_a_q;
    logic [1:0]        wi_q;
    logic              busy_q;
    logic [W-1:0]      q_q;
    logic              oe_q;
    logic              va_q;
    logic              echo_q;
    logic              echo_n_q;
    logic [LW-1:0]     lock_cnt_q;
    logic              locked_q;
    logic [CW-1:0]     cal_cnt_q;
    logic              cal_q;

    // Byte-masked merge: low select writes, high keeps old byte
    function automatic logic [W-1:0] merge(
        input logic [W-1:0]  old_w,
        input logic [W-1:0]  new_w,
        input logic [NB-1:0] sel_n
    );
        logic [W-1:0] o;
        o = old_w;
        for (int b = 0; b < NB; b++)
        begin
            if (!sel_n[b])
                o[b*BW +: BW] = new_w[b*BW +: BW];
        end
        return o;
    endfunction

    // Word fetch with forwarding from an uncommitted write
    function automatic logic [W-1:0] fetch(
        input logic [AW-1:0] a,
        input logic [1:0]    i
    );
        logic [W-1:0] w;
        w = mem[{a, i}];
        if (wb_vld_q[i] && wb_a_q == a)
            w = merge(w, wb_d_q[i], wb_m_q[i]);
        return w;
    endfunction

    // Loop disable strap comes from outside the link domain
    always_ff @(posedge lnk.beat_clk)
    begin
        if (!rst_b)
        begin
            ld_s1_q <= 1'b1;
            ld_s2_q <= 1'b1;
        end
        else
        begin
            ld_s1_q <= loop_disable_n;
            ld_s2_q <= ld_s1_q;
        end
    end

    // Selects only count on K beats; previous op arbitrates
    always_comb
    begin
        rd_go = lnk.k_true && !lnk.read_port_select_n
                && last_q != burst4_pkg::OP_RD;
        wr_go = lnk.k_true && !lnk.write_port_select_n
                && last_q != burst4_pkg::OP_WR && !rd_go;
    end

    // Last started operation, updated on every K rise
    always_ff @(posedge lnk.beat_clk)
    begin
        if (!rst_b)
            last_q <= burst4_pkg::OP_IDLE;
        else if (lnk.k_true)
        begin
            if (rd_go)
                last_q <= burst4_pkg::OP_RD;
            else if (wr_go)
                last_q <= burst4_pkg::OP_WR;
            else
                last_q <= burst4_pkg::OP_IDLE;
        end
    end

    // Read start delay line with the latched addresses
    always_ff @(posedge lnk.beat_clk)
    begin
        if (!rst_b)
            rg_q <= '0;
        else
            rg_q <= {rg_q[burst4_pkg::RD_PIPE-2:0], rd_go};
    end

    // Addresses ride along; no reset needed on data path
    always_ff @(posedge lnk.beat_clk)
    begin
        ra_q[0] <= lnk.addr;
        for (int i = 1; i < burst4_pkg::RD_PIPE; i++)
            ra_q[i] <= ra_q[i-1];
    end

    // Latency picks the delay-line tap
    always_comb
    begin
        lat      = ld_s2_q ? 3'(burst4_pkg::LAT_LOOP_BEATS)
                           : 3'(burst4_pkg::LAT_LEG_BEATS);
        rd_start = rg_q[lat - 3'd1];
        rd_pre   = rg_q[lat - 3'd2];
    end

    // Read output registers; one word launched per beat of a burst
    always_ff @(posedge lnk.beat_clk)
    begin
        if (!rst_b)
        begin
            q_q     <= '0;
            oe_q    <= 1'b0;
            va_q    <= 1'b0;
            busy_q  <= 1'b0;
            wi_q    <= 2'd0;
            cur_a_q <= '0;
        end
        else
        begin
            va_q <= rd_pre || rd_start || (busy_q && wi_q != 2'd3);
            if (rd_start)
            begin
                q_q     <= fetch(ra_q[lat - 3'd1], 2'd0);
                cur_a_q <= ra_q[lat - 3'd1];
                wi_q    <= 2'd1;
                busy_q  <= 1'b1;
                oe_q    <= 1'b1;
            end
            else if (busy_q)
            begin
                q_q    <= fetch(cur_a_q, wi_q);
                wi_q   <= wi_q + 2'd1;
                busy_q <= wi_q != 2'd3;
            end
            else if (!lnk.k_true)
                oe_q <= 1'b0;
        end
    end

    // Write slot delay line and pending address
    always_ff @(posedge lnk.beat_clk)
    begin
        if (!rst_b)
        begin
            wg_q     <= '0;
            pend_a_q <= '0;
        end
        else
        begin
            wg_q <= {wg_q[burst4_pkg::WR_LAST_SLOT-2:0], wr_go};
            if (wr_go)
                pend_a_q <= lnk.addr;
        end
    end

    // Capture four words with their byte selects, one per beat
    always_ff @(posedge lnk.beat_clk)
    begin
        if (!rst_b)
        begin
            wb_vld_q <= '0;
            wb_a_q   <= '0;
        end
        else if (wg_q[1])
        begin
            wb_a_q    <= pend_a_q;
            wb_vld_q  <= 4'h1;
            wb_d_q[0] <= lnk.wdata;
            wb_m_q[0] <= lnk.byte_write_select_n;
        end
        else
        begin
            // Only scheduled slots listen, so a deselected port is ignored
            for (int k = 1; k < burst4_pkg::BURST; k++)
            begin
                if (wg_q[k+1])
                begin
                    wb_d_q[k]   <= lnk.wdata;
                    wb_m_q[k]   <= lnk.byte_write_select_n;
                    wb_vld_q[k] <= 1'b1;
                end
            end
        end
    end

    // Commit all four words when the last one arrives
    always_ff @(posedge lnk.beat_clk)
    begin
        if (wg_q[burst4_pkg::WR_LAST_SLOT-1])
        begin
            for (int k = 0; k < burst4_pkg::BURST - 1; k++)
                mem[{wb_a_q, 2'(k)}] <= merge(mem[{wb_a_q, 2'(k)}],
                                              wb_d_q[k], wb_m_q[k]);
            mem[{wb_a_q, 2'd3}] <= merge(mem[{wb_a_q, 2'd3}], lnk.wdata,
                                         lnk.byte_write_select_n);
        end
    end

    // Echo clocks follow the beat phase
    always_ff @(posedge lnk.beat_clk)
    begin
        if (!rst_b)
        begin
            echo_q   <= 1'b0;
            echo_n_q <= 1'b1;
        end
        else
        begin
            echo_q   <= lnk.k_true;
            echo_n_q <= !lnk.k_true;
        end
    end

    // Lock timer; a stopped clock is seen only via host reset
    always_ff @(posedge lnk.beat_clk)
    begin
        if (!rst_b || !ld_s2_q)
        begin
            lock_cnt_q <= '0;
            locked_q   <= 1'b0;
        end
        else if (lnk.k_true && !locked_q)
        begin
            lock_cnt_q <= lock_cnt_q + 1'b1;
            locked_q   <= lock_cnt_q == LW'(burst4_pkg::LOCK_K_CYCLES - 1);
        end
    end

    // Impedance update pulse once per 1024 K cycles
    always_ff @(posedge lnk.beat_clk)
    begin
        if (!rst_b)
        begin
            cal_cnt_q <= '0;
            cal_q     <= 1'b0;
        end
        else
        begin
            cal_q <= lnk.k_true && cal_cnt_q == CW'(burst4_pkg::CAL_K_CYCLES - 1);
            if (lnk.k_true)
                cal_cnt_q <= cal_cnt_q + 1'b1;
        end
    end

    assign lnk.rdata           = q_q;
    assign lnk.rdata_oe        = oe_q;
    assign lnk.read_valid_flag = va_q;
    assign lnk.echo_clock      = echo_q;
    assign lnk.echo_clock_n    = echo_n_q;
    assign loop_locked         = locked_q;
    assign cal_tick            = cal_q;
endmodule
`default_nettype wire

// [hw/burst4_mem_host.sv]
// Memory controller end: makes the beat clock and runs bursts
`timescale 1ns/1ns
`default_nettype none
module burst4_mem_host #(
    parameter int AW   = burst4_pkg::ADDR_W,
    parameter int HALF = 1
) (
    burst4_if.host                    lnk,
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire logic                 cmd_valid,
    input  wire logic                 cmd_write,
    input  wire logic [AW-1:0]        cmd_addr,
    input  wire logic [4*18-1:0]      cmd_wdata,
    input  wire logic [7:0]           cmd_byte_n,
    input  wire logic                 loop_reset,
    output logic                      rd_ready,
    output logic                      wr_ready,
    output logic                      link_up,
    output logic [4*18-1:0]           rd_data,
    output logic                      rd_done
);
    localparam int W  = burst4_pkg::DATA_W;
    localparam int NB = W / burst4_pkg::BYTE_W;
    localparam int TW = $clog2(burst4_pkg::LOCK_WAIT_CYC + 1);

    burst4_pkg::host_state_e st_q;
    burst4_pkg::op_e         last_q;
    burst4_pkg::op_e         last_d;
    logic [7:0]    div_q;
    logic [7:0]    div_d;
    logic          beat_q;
    logic          beat_d;
    logic          nxt_k_q;
    logic          nxt_k_d;
    logic          running;
    logic          tick;
    logic          launch;
    logic          rise;
    logic          take_rd;
    logic          take_wr;
    logic [2:0]    wcnt_q;
    logic [2:0]    wcnt_d;
    logic [TW-1:0] tmr_q;
    logic [4*W-1:0]  wbuf_q;
    logic [4*NB-1:0] mbuf_q;
    logic          rps_n_q;
    logic          wps_n_q;
    logic          kt_q;
    logic [AW-1:0] addr_q;
    logic [W-1:0]  wd_q;
    logic [NB-1:0] bws_n_q;
    logic          rdy_r_q;
    logic          rdy_w_q;
    logic [W-1:0]  rq_s1_q;
    logic [W-1:0]  rq_s2_q;
    logic          rv_s1_q;
    logic          rv_s2_q;
    logic          vprev_q;
    logic [1:0]    rcnt_q;
    logic [4*W-1:0] rbuf_q;
    logic [4*W-1:0] rdat_q;
    logic          done_q;

    // Beat clock divider and next-state terms
    always_comb
    begin
        running = st_q != burst4_pkg::HS_STOP;
        tick    = div_q == 8'(HALF - 1);
        launch  = running && tick && beat_q;
        rise    = running && tick && !beat_q;
        take_rd = launch && nxt_k_q && rdy_r_q && cmd_valid && !cmd_write;
        take_wr = launch && nxt_k_q && rdy_w_q && cmd_valid && cmd_write;
        beat_d  = !running ? 1'b0 : (tick ? !beat_q : beat_q);
        div_d   = (!running || tick) ? 8'h00 : div_q + 8'h01;
        nxt_k_d = launch ? !nxt_k_q : nxt_k_q;
        last_d  = last_q;
        if (launch && nxt_k_q)
            last_d = take_rd ? burst4_pkg::OP_RD
                   : (take_wr ? burst4_pkg::OP_WR : burst4_pkg::OP_IDLE);
        wcnt_d  = wcnt_q;
        if (take_wr)
            wcnt_d = 3'd1;
        else if (launch && wcnt_q != 3'd0)
            wcnt_d = (wcnt_q == 3'(burst4_pkg::WR_LAST_SLOT)) ? 3'd0 : wcnt_q + 3'd1;
    end

    // Clock, phase, spacing bookkeeping
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            beat_q  <= 1'b0;
            div_q   <= 8'h00;
            nxt_k_q <= 1'b1;
            last_q  <= burst4_pkg::OP_IDLE;
            wcnt_q  <= 3'd0;
        end
        else
        begin
            beat_q  <= beat_d;
            div_q   <= div_d;
            nxt_k_q <= nxt_k_d;
            last_q  <= last_d;
            wcnt_q  <= wcnt_d;
        end
    end

    // Lock wait, run, and clock stop for loop reset
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            st_q  <= burst4_pkg::HS_WAIT;
            tmr_q <= '0;
        end
        else
        begin
            case (st_q)
                burst4_pkg::HS_WAIT:
                begin
                    tmr_q <= tmr_q + 1'b1;
                    if (tmr_q == TW'(burst4_pkg::LOCK_WAIT_CYC - 1))
                        st_q <= burst4_pkg::HS_RUN;
                end
                burst4_pkg::HS_RUN:
                begin
                    tmr_q <= '0;
                    // Stop only when no write data is owed
                    if (loop_reset && launch && !take_rd && !take_wr && wcnt_q == 3'd0)
                        st_q <= burst4_pkg::HS_STOP;
                end
                burst4_pkg::HS_STOP:
                begin
                    tmr_q <= tmr_q + 1'b1;
                    if (tmr_q == TW'(burst4_pkg::STOP_CYC - 1))
                    begin
                        tmr_q <= '0;
                        st_q  <= burst4_pkg::HS_WAIT;
                    end
                end
                default: st_q <= burst4_pkg::HS_WAIT;
            endcase
        end
    end

    // Ready for the next launch; same-type starts one K apart refused
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            rdy_r_q <= 1'b0;
            rdy_w_q <= 1'b0;
        end
        else
        begin
            rdy_r_q <= st_q == burst4_pkg::HS_RUN && beat_d && div_d == 8'(HALF - 1)
                       && nxt_k_d && !loop_reset
                       && last_d != burst4_pkg::OP_RD;
            rdy_w_q <= st_q == burst4_pkg::HS_RUN && beat_d && div_d == 8'(HALF - 1)
                       && nxt_k_d && !loop_reset && wcnt_d == 3'd0
                       && last_d != burst4_pkg::OP_WR;
        end
    end

    // Launch selects, address and write words at beat fall
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            rps_n_q <= 1'b1;
            wps_n_q <= 1'b1;
            kt_q    <= 1'b1;
            addr_q  <= '0;
            wd_q    <= '0;
            bws_n_q <= '1;
            wbuf_q  <= '0;
            mbuf_q  <= '1;
        end
        else if (launch)
        begin
            kt_q    <= nxt_k_q;
            rps_n_q <= !take_rd;
            wps_n_q <= !take_wr;
            if (take_rd || take_wr)
                addr_q <= cmd_addr;
            if (take_wr)
            begin
                wbuf_q <= cmd_wdata;
                mbuf_q <= cmd_byte_n;
            end
            if (wcnt_q >= 3'd2)
            begin
                wd_q    <= wbuf_q[(wcnt_q - 3'd2) * W +: W];
                bws_n_q <= mbuf_q[(wcnt_q - 3'd2) * NB +: NB];
            end
            else
            begin
                wd_q    <= '0;
                bws_n_q <= '1;
            end
        end
    end

    // Read pins pass two flops before use
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            rq_s1_q <= '0;
            rq_s2_q <= '0;
            rv_s1_q <= 1'b0;
            rv_s2_q <= 1'b0;
        end
        else
        begin
            rq_s1_q <= lnk.rdata;
            rq_s2_q <= rq_s1_q;
            rv_s1_q <= lnk.read_valid_flag;
            rv_s2_q <= rv_s1_q;
        end
    end

    // Valid leads data by a beat, so gather on the previous flag
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            vprev_q <= 1'b0;
            rcnt_q  <= 2'd0;
            rbuf_q  <= '0;
            rdat_q  <= '0;
            done_q  <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            if (rise)
            begin
                vprev_q <= rv_s2_q;
                if (vprev_q)
                begin
                    rbuf_q <= {rq_s2_q, rbuf_q[4*W-1:W]};
                    rcnt_q <= rcnt_q + 2'd1;
                    if (rcnt_q == 2'd3)
                    begin
                        rdat_q <= {rq_s2_q, rbuf_q[4*W-1:W]};
                        done_q <= 1'b1;
                    end
                end
            end
        end
    end

    // Link-up flag for the user side
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            link_up <= 1'b0;
        else
            link_up <= st_q == burst4_pkg::HS_RUN;
    end

    assign lnk.beat_clk            = beat_q;
    assign lnk.k_true              = kt_q;
    assign lnk.read_port_select_n  = rps_n_q;
    assign lnk.write_port_select_n = wps_n_q;
    assign lnk.addr                = addr_q;
    assign lnk.wdata               = wd_q;
    assign lnk.byte_write_select_n = bws_n_q;
    assign rd_ready                = rdy_r_q;
    assign wr_ready                = rdy_w_q;
    assign rd_data                 = rdat_q;
    assign rd_done                 = done_q;
endmodule
`default_nettype wire

// [tb/burst4_link_chk.sv]
// Link assertions for the burst-four memory end
`timescale 1ns/1ns
`default_nettype none
module burst4_link_chk (
    input wire logic beat_clk,
    input wire logic rst_b,
    input wire logic k_true,
    input wire logic read_port_select_n,
    input wire logic rdata_oe,
    input wire logic read_valid_flag,
    input wire logic echo_clock,
    input wire logic echo_clock_n
);
    // All checks live in the beat clock domain of the memory end
    default clocking cb @(posedge beat_clk);
    endclocking
    default disable iff (!rst_b);

    a_valid_leads_word: assert property ($rose(rdata_oe) |-> $past(read_valid_flag))
        else $error("word without earlier valid");
    a_valid_then_word: assert property (read_valid_flag |=> rdata_oe)
        else $error("valid without word");
    a_burst_four_words: assert property ($rose(rdata_oe) |-> rdata_oe [*4])
        else $error("burst under four words");
    a_release_on_kn: assert property ($fell(rdata_oe) |-> !$past(k_true))
        else $error("release not on K# beat");
    a_read_answered: assert property (k_true && !read_port_select_n |-> ##[1:5] read_valid_flag)
        else $error("read got no valid");
    a_echo_true_beat: assert property (k_true |=> echo_clock && !echo_clock_n)
        else $error("echo wrong after K");
    a_echo_comp_beat: assert property (!k_true |=> !echo_clock && echo_clock_n)
        else $error("echo wrong after K#");
    a_reset_quiet: assert property (disable iff (1'b0) !rst_b |=> !rdata_oe && !read_valid_flag)
        else $error("outputs live in reset");
endmodule
`default_nettype wire

// [tb/dual_port_burst4_sram_core_tb.sv]
// Bench joining controller and memory ends over the link
`timescale 1ns/1ns
`default_nettype none
module dual_port_burst4_sram_core_tb;
    logic        clk, rst_b, dev_rst_b, loop_disable_n, loop_reset, cmd_valid, cmd_write;
    logic        rd_ready, wr_ready, link_up, rd_done, loop_locked;
    logic [7:0]  cmd_addr, cmd_byte_n, a;
    logic [71:0] cmd_wdata, rd_data;
    logic [15:0] lfsr_q;
    logic [17:0] ref_mem [0:1023];
    int          errors, checks_done;
    int          k_beats;
    logic        cal_tick, cal_exp;

    burst4_if lnk ();
    burst4_mem_host burst4_mem_host_inst (.lnk(lnk), .clk(clk), .rst_b(rst_b),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .cmd_byte_n(cmd_byte_n), .loop_reset(loop_reset),
        .rd_ready(rd_ready), .wr_ready(wr_ready), .link_up(link_up),
        .rd_data(rd_data), .rd_done(rd_done));
    burst4_mem_device burst4_mem_device_inst (.lnk(lnk), .rst_b(dev_rst_b),
        .loop_disable_n(loop_disable_n), .loop_locked(loop_locked), .cal_tick(cal_tick));
    burst4_link_chk burst4_link_chk_inst (.beat_clk(lnk.beat_clk), .rst_b(dev_rst_b),
        .k_true(lnk.k_true), .read_port_select_n(lnk.read_port_select_n),
        .rdata_oe(lnk.rdata_oe), .read_valid_flag(lnk.read_valid_flag),
        .echo_clock(lnk.echo_clock), .echo_clock_n(lnk.echo_clock_n));

    // 100 MHz system clock
    always #5 clk = ~clk;

    // Impedance tick must follow each 1024th K beat by one beat
    always @(posedge lnk.beat_clk)
    begin
        if (dev_rst_b)
            chk("cal_tick", cal_tick, cal_exp);
        cal_exp = dev_rst_b && lnk.k_true
                  && k_beats % burst4_pkg::CAL_K_CYCLES == burst4_pkg::CAL_K_CYCLES - 1;
        k_beats = dev_rst_b ? k_beats + int'(lnk.k_true) : 0;
    end

    // Shift register for repeatable stimulus
    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    // High select keeps the stored byte
    function automatic logic [17:0] merge(input logic [17:0] o, w, input logic [1:0] s);
        return {s[1] ? o[17:9] : w[17:9], s[0] ? o[8:0] : w[8:0]};
    endfunction

    task automatic chk(input string name, input logic [71:0] seen, exp);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %s exp %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_sim();
        if (errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Skip an edge first so valid is never set twice in one step
    task automatic op(input logic wr, input logic [7:0] ad, input logic [71:0] d,
                      input logic [7:0] bn);
        int n;
        @(posedge clk) #1;
        {cmd_valid, cmd_write, cmd_addr, cmd_wdata, cmd_byte_n} = {1'b1, wr, ad, d, bn};
        n = 0;
        while ((wr ? wr_ready : rd_ready) !== 1'b1 && n++ < 300)
            @(posedge clk) #1;
        @(posedge clk) #1;
        cmd_valid = 1'b0;
        for (int k = 0; k < 4 && wr; k++)
            ref_mem[{ad, 2'(k)}] = merge(ref_mem[{ad, 2'(k)}], d[18*k +: 18], bn[2*k +: 2]);
    endtask

    task automatic rd_chk(input logic [7:0] ad);
        int          n;
        logic [71:0] e;
        e = {ref_mem[{ad, 2'd3}], ref_mem[{ad, 2'd2}], ref_mem[{ad, 2'd1}], ref_mem[{ad, 2'd0}]};
        op(1'b0, ad, 72'h0, 8'hff);
        n = 0;
        while (rd_done !== 1'b1 && n++ < 100)
            @(posedge clk) #1;
        chk("rd_done", rd_done, 72'h1);
        chk("rd_data", rd_data, e);
        repeat (4) @(posedge clk) #1;
        chk("rdata_oe", lnk.rdata_oe, 72'h0);
    endtask

    task automatic wait_up();
        int n;
        n = 0;
        while (link_up !== 1'b1 && n++ < 5000)
            @(posedge clk) #1;
        chk("link_up", link_up, 72'h1);
    endtask

    // Reset, random and corner bursts, legacy latency, loop restart
    initial
    begin
        clk = 1'b0;
        rst_b = 1'b0;
        dev_rst_b = 1'b0;
        loop_disable_n = 1'b1;
        loop_reset = 1'b0;
        {cmd_valid, cmd_write, cmd_addr, cmd_wdata, cmd_byte_n} = '0;
        errors = 0;
        checks_done = 0;
        lfsr_q = 16'h180b;
        repeat (6) @(posedge clk) #1;
        rst_b = 1'b1;
        // Memory end needs running beats to see its reset
        repeat (12) @(posedge clk) #1;
        dev_rst_b = 1'b1;
        chk("reset state", {lnk.rdata_oe, lnk.read_port_select_n}, 72'h1);
        wait_up();
        chk("loop_locked", loop_locked, 72'h1);
        for (int i = 0; i < 16; i++)
        begin
            lfsr_q = lfsr_next(lfsr_q);
            a = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : lfsr_q[7:0];
            op(1'b1, a, {lfsr_q, ~lfsr_q, lfsr_q ^ 16'h5a5a, lfsr_q[7:0], ~lfsr_q}, 8'h00);
            lfsr_q = lfsr_next(lfsr_q);
            op(1'b1, a, {~lfsr_q, lfsr_q[11:4], lfsr_q, lfsr_q ^ 16'h3c3c, lfsr_q},
               (i == 0) ? 8'hff : (i == 1) ? 8'h9c : lfsr_q[15:8]);
            rd_chk(a);
        end
        loop_disable_n = 1'b0;
        repeat (10) @(posedge clk) #1;
        // Write just before the short-latency read so forwarding is exercised
        op(1'b1, 8'h00, {lfsr_q, lfsr_q, lfsr_q, lfsr_q, lfsr_q[7:0]}, 8'h5a);
        rd_chk(8'h00);
        loop_disable_n = 1'b1;
        loop_reset = 1'b1;
        repeat (10) @(posedge clk) #1;
        chk("link_up held", link_up, 72'h0);
        loop_reset = 1'b0;
        wait_up();
        rd_chk(8'hff);
        end_sim();
    end

    // Hang guard, well past the expected run length
    initial
    begin
        #300000;
        errors++;
        end_sim();
    end
endmodule
`default_nettype wire
